// ==== design/csp_consts.svh ====
// Named constants of the system clock select and prescale block.
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH

`define CSP_ADDR_W 4
`define CSP_OFS_CTRL 4'h0
`define CSP_OFS_PRESC 4'h4
`define CSP_OFS_PROT 4'h8

`define CSP_BIT_RDY 7
`define CSP_BIT_TRIG 6
`define CSP_BIT_CKO 5
`define CSP_BIT_SUT 4

`define CSP_SEL_RST 4'h0
`define CSP_DIV_ONE 4'h0
`define CSP_DIV_EIGHT 4'h3
`define CSP_DIV_MAX 4'h8

`define CSP_CLK_MHZ 50
`define CSP_WAKE_SHORT_CK 24'h000006
`define CSP_RESET_CK 24'h00000E
`define CSP_WAKE_258_CK 24'h000102
`define CSP_WAKE_1K_CK 24'h000400
`define CSP_WAKE_16K_CK 16384
`define CSP_WAKE_32K_CK 32768
`define CSP_RESET_TIMEOUT_MS 16
`define CSP_RESET_TIMEOUT_CYC (`CSP_RESET_TIMEOUT_MS * 1000 * `CSP_CLK_MHZ)
`define CSP_BOD_WAKE_US 60
`define CSP_BOD_WAKE_CYC (`CSP_BOD_WAKE_US * `CSP_CLK_MHZ)
`define CSP_UNLOCK_TICKS 3'h4
`define CSP_CNT_ZERO 24'h000000
`define CSP_CNT_ONE 24'h000001

// Unlock signature value is arbitrary.
`define CSP_UNLOCK_SIG 8'hA5

`endif

// ==== design/csp_pkg.sv ====
// Types shared by the system clock select and prescale block.
package csp_pkg;
  typedef logic [23:0] csp_cnt_t;
  typedef enum logic [1:0] {
    CSP_ST_RESET_WAIT = 2'b00,
    CSP_ST_RUN = 2'b01,
    CSP_ST_WAKE = 2'b10
  } csp_state_t;
endpackage

// ==== design/csp_divider.sv ====
// Prescaler divider that changes ratio only at a period boundary.
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_divider #(
  parameter int SEL_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [SEL_W-1:0] init_sel_i,
  input wire logic [SEL_W-1:0] new_sel_i,
  input wire logic new_sel_we_i,
  output logic tick_o,
  output logic [SEL_W-1:0] active_sel_o
);
  logic [7:0] cnt_reg;
  logic [SEL_W-1:0] active_reg;
  logic [SEL_W-1:0] pend_reg;
  logic pend_valid_reg;
  logic tick_reg;
  logic [7:0] last;
  logic at_end;

  // Period length minus one, a power of two.
  assign last = 8'((9'h001 << active_reg) - 9'h001);
  assign at_end = (cnt_reg == last);

  // Counter is clocked by the undivided source clock; not visible to software.
  always_ff @(posedge clk_i) begin
    if (rst_i || at_end) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // A new ratio waits for the end of the running period, so the next
  // period is a whole new one: two active edges in old plus new period.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_reg <= init_sel_i;
      pend_reg <= init_sel_i;
      pend_valid_reg <= 1'b0;
    end else begin
      if (new_sel_we_i) begin
        pend_reg <= new_sel_i;
        pend_valid_reg <= 1'b1;
      end else if (at_end) begin
        pend_valid_reg <= 1'b0;
      end
      if (at_end && pend_valid_reg) begin
        active_reg <= pend_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= at_end;
    end
  end

  assign tick_o = tick_reg;
  assign active_sel_o = active_reg;
endmodule

// ==== design/csp_clock_ctrl.sv ====
// System clock source select, start-up timing and prescaler control.
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_clock_ctrl #(
  parameter int RESET_TIMEOUT_CYC = `CSP_RESET_TIMEOUT_CYC,
  parameter int WAKE_16K_CYC = `CSP_WAKE_16K_CK,
  parameter int WAKE_32K_CYC = `CSP_WAKE_32K_CK
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`CSP_ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [3:0] fuse_source_select_i,
  input wire logic fuse_startup_option_i,
  input wire logic fuse_clock_output_i,
  input wire logic fuse_initial_divide_by_eight_i,
  input wire logic power_down_wake_i,
  input wire logic brownout_detector_off_i,
  output logic clk_io_en_o,
  output logic clk_adc_en_o,
  output logic clk_cpu_en_o,
  output logic clk_flash_en_o,
  output logic cpu_run_o,
  output logic [3:0] osc_enable_select_o,
  output logic [3:0] active_source_o,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe_o
);
  localparam csp_pkg::csp_cnt_t RESET_WAIT = csp_pkg::csp_cnt_t'(RESET_TIMEOUT_CYC) + `CSP_RESET_CK;
  localparam csp_pkg::csp_cnt_t BOD_WAIT = csp_pkg::csp_cnt_t'(`CSP_BOD_WAKE_CYC);
  localparam csp_pkg::csp_cnt_t W16K = csp_pkg::csp_cnt_t'(WAKE_16K_CYC);
  localparam csp_pkg::csp_cnt_t W32K = csp_pkg::csp_cnt_t'(WAKE_32K_CYC);

  // Power-down wake delay for a select and start-up option; zero marks a reserved pair.
  function automatic csp_pkg::csp_cnt_t startup_delay(input logic [3:0] sel, input logic startup_option);
    csp_pkg::csp_cnt_t d;
    d = `CSP_CNT_ZERO;
    case (sel)
      4'h0: d = startup_option ? `CSP_CNT_ZERO : `CSP_WAKE_SHORT_CK;
      4'h2: d = startup_option ? `CSP_CNT_ZERO : `CSP_WAKE_SHORT_CK;
      4'h4: d = startup_option ? `CSP_CNT_ZERO : `CSP_WAKE_SHORT_CK;
      4'h6: d = startup_option ? W32K : `CSP_WAKE_1K_CK;
      4'h8: d = startup_option ? `CSP_WAKE_1K_CK : `CSP_WAKE_258_CK;
      4'h9: d = startup_option ? `CSP_CNT_ZERO : W16K;
      4'hA: d = startup_option ? `CSP_WAKE_1K_CK : `CSP_WAKE_258_CK;
      4'hB: d = startup_option ? `CSP_CNT_ZERO : W16K;
      4'hC: d = startup_option ? `CSP_WAKE_1K_CK : `CSP_WAKE_258_CK;
      4'hD: d = startup_option ? `CSP_CNT_ZERO : W16K;
      4'hE: d = startup_option ? `CSP_WAKE_1K_CK : `CSP_WAKE_258_CK;
      4'hF: d = startup_option ? `CSP_CNT_ZERO : W16K;
      default: d = `CSP_CNT_ZERO;
    endcase
    return d;
  endfunction

  logic ack_reg;
  logic [31:0] dat_reg;
  logic [3:0] src_sel_reg;
  logic [3:0] active_src_reg;
  logic switch_pend_reg;
  logic sut_reg;
  logic cko_reg;
  logic [3:0] div_sel_reg;
  logic [2:0] unlock_reg;
  logic rdy_reg;
  csp_pkg::csp_cnt_t rdy_cnt_reg;
  csp_pkg::csp_state_t state_reg;
  csp_pkg::csp_cnt_t run_cnt_reg;
  logic pin_reg;
  logic pin_oe_reg;
  logic tick;
  logic [3:0] div_active;
  logic bus_req;
  logic wr_ctrl;
  logic wr_presc;
  logic wr_prot;
  logic unlocked;
  logic sel_ok;
  logic sel_wr;
  logic div_wr;
  logic [3:0] new_sel;
  logic new_sut;
  csp_pkg::csp_cnt_t wake_delay;
  logic [3:0] dom_en;

  // True at the acknowledged edge of a lane-0 write to the given register.
  function automatic logic reg_write(input logic [`CSP_ADDR_W-1:0] ofs);
    return cyc_i && stb_i && we_i && ack_reg && sel_i[0] && (adr_i == ofs);
  endfunction

  // Read value of one register; unmapped offsets and the trigger bit read zero.
  function automatic logic [31:0] read_word(input logic [`CSP_ADDR_W-1:0] ofs);
    logic [31:0] w;
    w = 32'h00000000;
    case (ofs)
      `CSP_OFS_CTRL: w = {24'h000000, rdy_reg, 1'b0, cko_reg, sut_reg, src_sel_reg};
      `CSP_OFS_PRESC: w = {28'h0000000, div_sel_reg};
      `CSP_OFS_PROT: w = {31'h00000000, unlocked};
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction

  function automatic logic [3:0] init_div(input logic div8);
    return div8 ? `CSP_DIV_EIGHT : `CSP_DIV_ONE;
  endfunction

  assign bus_req = cyc_i && stb_i;
  assign wr_ctrl = reg_write(`CSP_OFS_CTRL);
  assign wr_presc = reg_write(`CSP_OFS_PRESC);
  assign wr_prot = reg_write(`CSP_OFS_PROT);
  assign unlocked = (unlock_reg != 3'h0);
  assign new_sel = dat_i[3:0];
  assign new_sut = dat_i[`CSP_BIT_SUT];
  assign sel_ok = (startup_delay(new_sel, new_sut) != `CSP_CNT_ZERO);
  assign sel_wr = wr_ctrl && unlocked && sel_ok;
  assign div_wr = wr_presc && unlocked && (dat_i[3:0] <= `CSP_DIV_MAX);

  // Wishbone slave: ack one cycle after the request, writes act on the ack edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h00000000;
    end else if (bus_req && !ack_reg) begin
      dat_reg <= read_word(adr_i);
    end
  end

  // The unlock window counts instruction cycles, one per CPU clock tick.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_reg <= 3'h0;
    end else if (wr_prot && (dat_i[7:0] == `CSP_UNLOCK_SIG)) begin
      unlock_reg <= `CSP_UNLOCK_TICKS;
    end else if (sel_wr || div_wr) begin
      unlock_reg <= 3'h0;
    end else if (unlocked && clk_cpu_en_o) begin
      unlock_reg <= unlock_reg - 3'h1;
    end
  end

  // Fuse copies load on every reset; bits 5 and 4 are plain read-write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cko_reg <= fuse_clock_output_i;
    end else if (wr_ctrl) begin
      cko_reg <= dat_i[`CSP_BIT_CKO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sut_reg <= fuse_startup_option_i;
    end else if (wr_ctrl) begin
      sut_reg <= dat_i[`CSP_BIT_SUT];
    end
  end

  // Select writes enable the oscillator; the trigger also switches the source.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_sel_reg <= fuse_source_select_i;
    end else if (sel_wr) begin
      src_sel_reg <= new_sel;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      switch_pend_reg <= 1'b0;
    end else if (sel_wr && dat_i[`CSP_BIT_TRIG]) begin
      switch_pend_reg <= 1'b1;
    end else if (tick) begin
      switch_pend_reg <= 1'b0;
    end
  end

  // The source changes only at a period boundary so no short pulse appears.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_src_reg <= fuse_source_select_i;
    end else if (switch_pend_reg && tick) begin
      active_src_reg <= src_sel_reg;
    end
  end

  // Ready clears on a new enable and sets when the time-out has run out.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_cnt_reg <= RESET_WAIT;
    end else if (sel_wr) begin
      rdy_cnt_reg <= startup_delay(new_sel, new_sut);
    end else if (rdy_cnt_reg != `CSP_CNT_ZERO) begin
      rdy_cnt_reg <= rdy_cnt_reg - `CSP_CNT_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_reg <= 1'b0;
    end else if (sel_wr) begin
      rdy_reg <= 1'b0;
    end else if (rdy_cnt_reg == `CSP_CNT_ZERO) begin
      rdy_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_sel_reg <= init_div(fuse_initial_divide_by_eight_i);
    end else if (div_wr) begin
      div_sel_reg <= dat_i[3:0];
    end
  end

  csp_divider #(
    .SEL_W(4)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .init_sel_i(init_div(fuse_initial_divide_by_eight_i)),
    .new_sel_i(dat_i[3:0]),
    .new_sel_we_i(div_wr),
    .tick_o(tick),
    .active_sel_o(div_active)
  );

  // Wake delay follows the table, stretched while the brown-out detector is off.
  always_comb begin
    wake_delay = startup_delay(active_src_reg, sut_reg);
    if (brownout_detector_off_i && (wake_delay < BOD_WAIT)) begin
      wake_delay = BOD_WAIT;
    end
  end

  // Execution is held through the reset time-out and any power-down wake-up.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= csp_pkg::CSP_ST_RESET_WAIT;
      run_cnt_reg <= RESET_WAIT;
    end else begin
      case (state_reg)
        csp_pkg::CSP_ST_RESET_WAIT, csp_pkg::CSP_ST_WAKE: begin
          if (run_cnt_reg == `CSP_CNT_ONE) begin
            state_reg <= csp_pkg::CSP_ST_RUN;
          end
          run_cnt_reg <= run_cnt_reg - `CSP_CNT_ONE;
        end
        csp_pkg::CSP_ST_RUN: begin
          if (power_down_wake_i) begin
            state_reg <= csp_pkg::CSP_ST_WAKE;
            run_cnt_reg <= wake_delay;
          end
        end
        default: begin
          state_reg <= csp_pkg::CSP_ST_RESET_WAIT;
          run_cnt_reg <= RESET_WAIT;
        end
      endcase
    end
  end

  assign cpu_run_o = (state_reg == csp_pkg::CSP_ST_RUN);

  // All four domains share the one divided tick; CPU and flash halt while held.
  // Indices 0 and 1 are the I/O and ADC domains, 2 and 3 the CPU and flash domains.
  for (genvar g = 0; g < 4; g++) begin : g_dom
    if (g < 2) begin : g_free
      assign dom_en[g] = tick;
    end else begin : g_held
      assign dom_en[g] = tick && cpu_run_o;
    end
  end

  assign clk_io_en_o = dom_en[0];
  assign clk_adc_en_o = dom_en[1];
  assign clk_cpu_en_o = dom_en[2];
  assign clk_flash_en_o = dom_en[3];

  // The pin toggles on each divided tick, so it runs at half the divided clock rate.
  always_ff @(posedge clk_i) begin
    if (rst_i || (state_reg == csp_pkg::CSP_ST_RESET_WAIT)) begin
      pin_reg <= 1'b0;
    end else if (cko_reg && tick) begin
      pin_reg <= !pin_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (state_reg == csp_pkg::CSP_ST_RESET_WAIT)) begin
      pin_oe_reg <= 1'b0;
    end else begin
      pin_oe_reg <= cko_reg;
    end
  end

  assign clock_output_pin_o = pin_reg;
  assign clock_output_pin_oe_o = pin_oe_reg;
  assign osc_enable_select_o = src_sel_reg;
  assign active_source_o = active_src_reg;
  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
endmodule

// ==== verification/csp_clock_ctrl_sva.sv ====
// Port assertions for the clock select and prescale block.
`timescale 1ns/1ps
module csp_clock_ctrl_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic power_down_wake_i,
  input wire logic clk_io_en_o,
  input wire logic clk_adc_en_o,
  input wire logic clk_cpu_en_o,
  input wire logic clk_flash_en_o,
  input wire logic cpu_run_o,
  input wire logic [3:0] active_source_o,
  input wire logic clock_output_pin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  a_domains_same: assert property (clk_adc_en_o == clk_io_en_o && clk_flash_en_o == clk_cpu_en_o)
    else $error("domains differ");
  a_cpu_gated: assert property (clk_cpu_en_o == (clk_io_en_o && cpu_run_o)) else $error("cpu tick wrong");
  a_pin_on_tick: assert property ($changed(clock_output_pin_o) |-> clk_io_en_o || $past(clk_io_en_o))
    else $error("pin moved off tick");
  a_quiet_after_rst: assert property ($past(rst_i) |-> !clock_output_pin_o && !cpu_run_o)
    else $error("active right after reset");
  a_switch_on_tick: assert property ($changed(active_source_o) |-> clk_io_en_o || $past(clk_io_en_o))
    else $error("source switched off tick");
  a_wake_stall: assert property (power_down_wake_i && cpu_run_o |=> !cpu_run_o [*5])
    else $error("wake too short");
endmodule
bind csp_clock_ctrl csp_clock_ctrl_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .power_down_wake_i(power_down_wake_i), .clk_io_en_o(clk_io_en_o), .clk_adc_en_o(clk_adc_en_o),
  .clk_cpu_en_o(clk_cpu_en_o), .clk_flash_en_o(clk_flash_en_o), .cpu_run_o(cpu_run_o),
  .active_source_o(active_source_o), .clock_output_pin_o(clock_output_pin_o));

// ==== verification/csp_clock_ctrl_tb.sv ====
// Self-checking bench for the clock select and prescale block.
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_clock_ctrl_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [3:0] fsel = 4'h2;
  logic fsut = 1'b0;
  logic fcko = 1'b1;
  logic fd8 = 1'b1;
  logic wake_i = 1'b0;
  logic bod_i = 1'b0;
  logic [31:0] dat_o, q;
  logic ack_o, io_en, adc_en, cpu_en, fl_en, run, pin, oe;
  logic [3:0] osc, act;
  int bad_count = 0;
  int samples_checked = 0;
  int p;
  always #10 clk_i = ~clk_i;
  csp_clock_ctrl #(.RESET_TIMEOUT_CYC(20), .WAKE_16K_CYC(40), .WAKE_32K_CYC(60)) dut_u (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .fuse_source_select_i(fsel), .fuse_startup_option_i(fsut),
    .fuse_clock_output_i(fcko), .fuse_initial_divide_by_eight_i(fd8), .power_down_wake_i(wake_i),
    .brownout_detector_off_i(bod_i), .clk_io_en_o(io_en), .clk_adc_en_o(adc_en), .clk_cpu_en_o(cpu_en),
    .clk_flash_en_o(fl_en), .cpu_run_o(run), .osc_enable_select_o(osc), .active_source_o(act),
    .clock_output_pin_o(pin), .clock_output_pin_oe_o(oe));
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    q = dat_o;
    if (n >= 20) bad_count++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    cmp(q, e);
  endtask
  task automatic unlock();
    wr(`CSP_OFS_PROT, {24'h000000, `CSP_UNLOCK_SIG});
  endtask
  // Counts the sampled edges at which execution is still held.
  task automatic low_len(output int n);
    n = 0;
    @(posedge clk_i);
    while (run !== 1'b1 && n < 5000) begin
      n++;
      @(posedge clk_i);
    end
  endtask
  task automatic wake(input int e);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    low_len(p);
    cmp(32'(p), 32'(e));
  endtask
  task automatic per(output int n);
    n = 0;
    while (io_en !== 1'b1 && n < 600) begin
      n++;
      @(posedge clk_i);
    end
    n = 1;
    @(posedge clk_i);
    while (io_en !== 1'b1 && n < 600) begin
      n++;
      @(posedge clk_i);
    end
  endtask
  task automatic tog(output int n);
    logic last;
    n = 0;
    last = pin;
    repeat (256) begin
      @(posedge clk_i);
      if (pin !== last) n++;
      last = pin;
    end
  endtask
  task automatic phase(input logic [3:0] s, input logic u, input logic c, input logic d, input int w);
    fsel <= s;
    fsut <= u;
    fcko <= c;
    fd8 <= d;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    low_len(p);
    cmp(32'(p), 32'h22);
    rd(`CSP_OFS_CTRL, {24'h000000, 1'b1, 1'b0, c, u, s});
    rd(`CSP_OFS_PRESC, d ? 32'h3 : 32'h0);
    cmp(oe, c);
    wake(w);
    $display("test reset with source %0h done", s);
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    end_of_test();
  end
  initial begin
    phase(4'h2, 1'b0, 1'b1, 1'b1, 6);
    for (int k = 0; k <= 8; k++) begin
      unlock();
      wr(`CSP_OFS_PRESC, 32'(k));
      rd(`CSP_OFS_PRESC, 32'(k));
      per(p);
      per(p);
      cmp(32'(p), 32'h1 << k);
      tog(p);
      cmp(32'(p), 32'h100 >> k);
    end
    unlock();
    wr(`CSP_OFS_PRESC, 32'h0);
    wr(`CSP_OFS_PRESC, 32'h2);
    rd(`CSP_OFS_PRESC, 32'h0);
    unlock();
    wr(`CSP_OFS_PRESC, 32'h9);
    rd(`CSP_OFS_PRESC, 32'h0);
    wr(`CSP_OFS_CTRL, 32'h02);
    @(posedge clk_i);
    cmp(oe, 1'b0);
    tog(p);
    cmp(32'(p), 32'h0);
    wr(`CSP_OFS_CTRL, 32'h22);
    $display("test prescaler and clock pin done");
    wr(`CSP_OFS_CTRL, 32'h6C);
    rd(`CSP_OFS_CTRL, 32'hA2);
    cmp(act, 4'h2);
    unlock();
    wr(`CSP_OFS_CTRL, 32'h2C);
    cmp(osc, 4'hC);
    cmp(act, 4'h2);
    rd(`CSP_OFS_CTRL, 32'h2C);
    repeat (300) @(posedge clk_i);
    rd(`CSP_OFS_CTRL, 32'hAC);
    unlock();
    wr(`CSP_OFS_CTRL, 32'h21);
    cmp(osc, 4'hC);
    unlock();
    wr(`CSP_OFS_CTRL, 32'h6C);
    repeat (4) @(posedge clk_i);
    cmp(act, 4'hC);
    wake(258);
    bod_i <= 1'b1;
    wake(`CSP_BOD_WAKE_CYC);
    bod_i <= 1'b0;
    $display("test source switching done");
    phase(4'hA, 1'b1, 1'b0, 1'b0, 1024);
    phase(4'h6, 1'b1, 1'b0, 1'b0, 60);
    end_of_test();
  end
endmodule
